// ===== ast_pkg.sv
// Shared constants and types for the asynchronous serial transceiver
package ast_pkg;

	// ==========================================================
	// Bus geometry and answers
	localparam int         ADDR_W      = 8;
	localparam int         DATA_W      = 32;
	localparam int         STRB_W      = 4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [5:0] IDX_BAUD   = 6'h09;
	localparam logic [5:0] IDX_CTRL   = 6'h0A;
	localparam logic [5:0] IDX_STATUS = 6'h0B;
	localparam logic [5:0] IDX_DATA   = 6'h0C;

	// ==========================================================
	// Control register fields
	localparam int CTL_RX_IRQ    = 7;
	localparam int CTL_TX_IRQ    = 6;
	localparam int CTL_EMPTY_IRQ = 5;
	localparam int CTL_RX_EN     = 4;
	localparam int CTL_TX_EN     = 3;
	localparam int CTL_NINE      = 2;
	localparam int CTL_TX_B8     = 0;

	// ==========================================================
	// Status register fields and reset values
	localparam int         ST_TX_DONE   = 6;
	localparam logic [7:0] STATUS_RESET = 8'h20;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] BAUD_RESET   = 8'h00;

	// ==========================================================
	// Oversampling points, counted from zero (sample n is n-1)
	localparam logic [3:0] SMP8     = 4'h7;
	localparam logic [3:0] SMP9     = 4'h8;
	localparam logic [3:0] SMP10    = 4'h9;
	localparam logic [3:0] SMP_LAST = 4'hF;

	// ==========================================================
	// Frame geometry
	localparam logic [3:0] TX_LEN8   = 4'hA;
	localparam logic [3:0] TX_LEN9   = 4'hB;
	localparam int         STOP_POS8 = 9;
	localparam int         STOP_POS9 = 10;
	localparam int         NINTH_POS = 9;
	localparam logic [3:0] RX_BITS8  = 4'h8;
	localparam logic [3:0] RX_BITS9  = 4'h9;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} ast_rx_state_t;

endpackage

// ===== ast_baud_gen.sv
// Divider making the sixteen-times-baud sampling tick
`timescale 1ns/1ps
module ast_baud_gen (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] baud_divide_value,
	output logic            tick16
);
	import ast_pkg::*;

	logic [7:0] div_cnt;

	wire wrap = (div_cnt >= baud_divide_value);

	// One tick every divider+1 clocks, so baud is clock/(16*(divider+1))
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 8'h00;
			tick16  <= 1'b0;
		end else begin
			div_cnt <= wrap ? 8'h00 : div_cnt + 8'h01;
			tick16  <= wrap;
		end
	end

endmodule

// ===== ast_transceiver.sv
// Full-duplex asynchronous serial transceiver with AXI4-Lite registers
// ==========================================================
// How it works
// - Writing the data register queues a character in the transmit holding register.
// - Holding loads the shifter at once when idle and the transmitter is enabled, else after the stop bit.
// - An idle load puts a low start bit at 0 and stop at 9 or 10; a chained load drives the start bit at once.
// - In nine-bit mode an idle load puts the transmit ninth bit into shifter position 9.
// - On the baud clock after an idle load, start, data LSB first, then stop go out.
// - Holding-empty sets when the shifter loads and clears on a data write.
// - Transmit-done sets after a full stop bit with nothing waiting.
// - Transmit-done clears on its vector acknowledge or a written one.
// - Transmitter enabled or still shifting drives the transmit pin as output, else general I/O.
// - Receiver samples at sixteen times baud; a low sample in idle is sample 1.
// - Two or more high samples of 8, 9, 10 reject the start bit.
// - Each data bit takes the majority of samples 8, 9, 10.
// - Low stop majority sets framing fault; a high stop bit clears it.
// - A finished character moves to the receive register and sets receive-done if the last one was read.
// - Data address reads the receive register and writes the holding register.
// - In nine-bit mode the received ninth bit is stored with the character.
// - A character finishing while unread is lost; overrun shows after the read.
// - Reading received data clears receive-done; handlers must read it.
// - Receiver enabled forces the receive pin to input; pull-up stays software's.
// - Separate enables gate three requests; the empty request lasts while empty.
// - Reset leaves holding-empty set and all other status flags clear.
// - Baud is clock divided by sixteen times divider plus one.
// - Nine-bit mode gives nine data bits between start and stop.
`timescale 1ns/1ps
module ast_transceiver (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [ast_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [ast_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [ast_pkg::STRB_W-1:0]  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ast_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [ast_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        tx_done_vec_ack,
	output logic                             irq_rx_done,
	output logic                             irq_tx_done,
	output logic                             irq_tx_empty,
	input  wire logic                        rx_pin_i,
	input  wire logic                        gpio_rx_out,
	input  wire logic                        rx_pin_dir_bit,
	input  wire logic                        rx_pin_pullup_bit,
	output logic                             rx_pin_o,
	output logic                             rx_pin_oe,
	output logic                             rx_pullup_en,
	input  wire logic                        gpio_tx_out,
	input  wire logic                        tx_pin_dir_bit,
	output logic                             tx_pin_o,
	output logic                             tx_pin_oe
);
	import ast_pkg::*;

	// ==========================================================
	// State
	logic [ADDR_W-1:0] aw_addr;
	logic              aw_held;
	logic [7:0]        w_byte;
	logic              w_lane0;
	logic              w_held;
	logic [7:0]        uart_control_bits;
	logic [7:0]        baud_divide_value;
	logic [7:0]        tx_hold;
	logic              tx_holding_empty;
	logic              tx_done_flag;
	logic              tx_busy;
	logic              tx_line;
	logic [10:0]       tx_shift;
	logic [3:0]        tx_left;
	logic [3:0]        tx_phase;
	logic [7:0]        rx_data;
	logic              rx_ninth_bit;
	logic              rx_full;
	logic              rx_done_flag;
	logic              framing_fault;
	logic              ovr_pend;
	logic              ovr_flag;
	ast_rx_state_t     rx_state;
	logic [3:0]        rx_cnt;
	logic [3:0]        rx_bits;
	logic [1:0]        rx_votes;
	logic [8:0]        rx_shift;
	logic              tick16;

	ast_baud_gen u_baud (
		.aclk              (aclk),
		.aresetn           (aresetn),
		.baud_divide_value (baud_divide_value),
		.tick16            (tick16)
	);

	// ==========================================================
	// Bus decode
	wire       aw_hs   = s_axi_awvalid & s_axi_awready;
	wire       w_hs    = s_axi_wvalid & s_axi_wready;
	wire       ar_hs   = s_axi_arvalid & s_axi_arready;
	wire       wr_fire = aw_held & w_held & ~s_axi_bvalid;
	wire [5:0] wr_idx  = aw_addr[ADDR_W-1:2];
	wire [5:0] rd_idx  = s_axi_araddr[ADDR_W-1:2];
	wire       wr_en   = wr_fire & w_lane0;
	wire       wr_hit  = (wr_idx == IDX_BAUD) | (wr_idx == IDX_CTRL) |
	                     (wr_idx == IDX_STATUS) | (wr_idx == IDX_DATA);
	wire       rd_hit  = (rd_idx == IDX_BAUD) | (rd_idx == IDX_CTRL) |
	                     (rd_idx == IDX_STATUS) | (rd_idx == IDX_DATA);
	wire       data_wr = wr_en & (wr_idx == IDX_DATA);
	wire       data_rd = ar_hs & (rd_idx == IDX_DATA);
	wire       ctrl_wr = wr_en & (wr_idx == IDX_CTRL);
	wire       baud_wr = wr_en & (wr_idx == IDX_BAUD);
	wire       done_clr_wr = wr_en & (wr_idx == IDX_STATUS) & w_byte[ST_TX_DONE];

	wire [7:0] uart_status_flags = {rx_done_flag, tx_done_flag, tx_holding_empty,
	                                framing_fault, ovr_flag, 3'h0};
	wire [7:0] ctrl_view = {uart_control_bits[7:2], rx_ninth_bit, 1'b0};
	wire [7:0] rd_byte = (rd_idx == IDX_BAUD)   ? baud_divide_value :
	                     (rd_idx == IDX_CTRL)   ? ctrl_view :
	                     (rd_idx == IDX_STATUS) ? uart_status_flags :
	                     (rd_idx == IDX_DATA)   ? rx_data : 8'h00;
	wire       next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

	wire tx_enable    = uart_control_bits[CTL_TX_EN];
	wire rx_enable    = uart_control_bits[CTL_RX_EN];
	wire nine_bit_chars = uart_control_bits[CTL_NINE];
	wire tx_ninth_bit = uart_control_bits[CTL_TX_B8];

	// ==========================================================
	// Register bus slave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			aw_addr       <= '0;
			w_held        <= 1'b0;
			w_byte        <= 8'h00;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (w_hs) begin
				w_held  <= 1'b1;
				w_byte  <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
			s_axi_awready <= ~(aw_hs | (aw_held & ~wr_fire));
			s_axi_wready  <= ~(w_hs | (w_held & ~wr_fire));
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (ar_hs) begin
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			uart_control_bits <= CTRL_RESET;
			baud_divide_value <= BAUD_RESET;
		end else begin
			if (ctrl_wr)
				uart_control_bits <= w_byte;
			if (baud_wr)
				baud_divide_value <= w_byte;
		end
	end

	// ==========================================================
	// Transmitter
	wire [10:0] tx_frame = nine_bit_chars ? {1'b1, tx_ninth_bit, tx_hold, 1'b0}
	                                      : {2'b11, tx_hold, 1'b0};
	wire [3:0]  tx_len   = nine_bit_chars ? TX_LEN9 : TX_LEN8;
	wire        tx_baud  = tick16 & (tx_phase == SMP_LAST);
	wire        tx_stop_end   = tx_baud & tx_busy & (tx_left == 4'h0);
	// Disabling waits for the shifter and a queued character to finish
	wire        tx_load_idle  = ~tx_holding_empty & ~tx_busy & tx_enable;
	wire        tx_load_chain = tx_stop_end & ~tx_holding_empty;
	wire        tx_load       = tx_load_idle | tx_load_chain;
	wire        tx_active     = tx_enable | tx_busy;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			tx_phase <= 4'h0;
		else if (tick16)
			tx_phase <= tx_phase + 4'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_busy  <= 1'b0;
			tx_line  <= 1'b1;
			tx_shift <= '1;
			tx_left  <= 4'h0;
		end else if (tx_load_idle) begin
			tx_busy  <= 1'b1;
			tx_shift <= tx_frame;
			tx_left  <= tx_len;
		end else if (tx_load_chain) begin
			tx_line  <= tx_frame[0];
			tx_shift <= {1'b1, tx_frame[10:1]};
			tx_left  <= tx_len - 4'h1;
		end else if (tx_stop_end) begin
			tx_busy <= 1'b0;
		end else if (tx_baud & tx_busy) begin
			tx_line  <= tx_shift[0];
			tx_shift <= {1'b1, tx_shift[10:1]};
			tx_left  <= tx_left - 4'h1;
		end
	end

	// A write in the load cycle keeps the new character, so empty stays clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold          <= 8'h00;
			tx_holding_empty <= STATUS_RESET[5];
			tx_done_flag     <= 1'b0;
		end else begin
			if (data_wr) begin
				tx_hold          <= w_byte;
				tx_holding_empty <= 1'b0;
			end else if (tx_load) begin
				tx_holding_empty <= 1'b1;
			end
			if (tx_stop_end & tx_holding_empty)
				tx_done_flag <= 1'b1;
			else if (done_clr_wr | tx_done_vec_ack)
				tx_done_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Receiver
	wire       rx_tick  = tick16 & rx_enable;
	wire       rx_maj   = (rx_votes[0] & rx_votes[1]) | (rx_votes[0] & rx_pin_i) |
	                      (rx_votes[1] & rx_pin_i);
	wire       rx_at10  = rx_tick & (rx_cnt == SMP10);
	wire       rx_finish = rx_at10 & (rx_state == RX_STOP);
	wire       rx_unread = rx_full & ~data_rd;
	wire       rx_deliver = rx_finish & ~rx_unread;
	wire       rx_lost  = rx_finish & rx_unread;
	wire [3:0] rx_need  = nine_bit_chars ? RX_BITS9 : RX_BITS8;
	wire [7:0] next_rx_data = nine_bit_chars ? rx_shift[7:0] : rx_shift[8:1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state <= RX_IDLE;
			rx_cnt   <= 4'h0;
			rx_bits  <= 4'h0;
			rx_votes <= 2'b00;
			rx_shift <= '0;
		end else if (!rx_enable) begin
			rx_state <= RX_IDLE;
		end else if (rx_tick) begin
			rx_cnt <= rx_cnt + 4'h1;
			if (rx_cnt == SMP8)
				rx_votes[0] <= rx_pin_i;
			if (rx_cnt == SMP9)
				rx_votes[1] <= rx_pin_i;
			case (rx_state)
				RX_IDLE: begin
					rx_cnt <= 4'h1;
					if (!rx_pin_i)
						rx_state <= RX_START;
				end
				RX_START: begin
					rx_bits <= 4'h0;
					if (rx_at10 & rx_maj)
						rx_state <= RX_IDLE;
					else if (rx_cnt == SMP_LAST)
						rx_state <= RX_DATA;
				end
				RX_DATA: begin
					if (rx_at10) begin
						rx_shift <= {rx_maj, rx_shift[8:1]};
						rx_bits  <= rx_bits + 4'h1;
					end
					if ((rx_cnt == SMP_LAST) & (rx_bits == rx_need))
						rx_state <= RX_STOP;
				end
				RX_STOP: begin
					if (rx_at10)
						rx_state <= RX_IDLE;
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Set wins over the read that would clear it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data       <= 8'h00;
			rx_ninth_bit  <= 1'b0;
			rx_full       <= 1'b0;
			rx_done_flag  <= 1'b0;
			framing_fault <= 1'b0;
			ovr_pend      <= 1'b0;
			ovr_flag      <= 1'b0;
		end else begin
			if (rx_deliver) begin
				rx_data <= next_rx_data;
				if (nine_bit_chars)
					rx_ninth_bit <= rx_shift[8];
			end
			if (rx_deliver)
				rx_full <= 1'b1;
			else if (data_rd)
				rx_full <= 1'b0;
			if (rx_deliver)
				rx_done_flag <= 1'b1;
			else if (data_rd)
				rx_done_flag <= 1'b0;
			if (rx_finish)
				framing_fault <= ~rx_maj;
			if (rx_lost)
				ovr_pend <= 1'b1;
			else if (data_rd)
				ovr_pend <= 1'b0;
			if (data_rd & ovr_pend)
				ovr_flag <= 1'b1;
			else if (rx_deliver)
				ovr_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Requests and pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_rx_done  <= 1'b0;
			irq_tx_done  <= 1'b0;
			irq_tx_empty <= 1'b0;
			tx_pin_o     <= 1'b1;
			tx_pin_oe    <= 1'b0;
			rx_pin_o     <= 1'b0;
			rx_pin_oe    <= 1'b0;
			rx_pullup_en <= 1'b0;
		end else begin
			irq_rx_done  <= rx_done_flag & uart_control_bits[CTL_RX_IRQ];
			irq_tx_done  <= tx_done_flag & uart_control_bits[CTL_TX_IRQ];
			irq_tx_empty <= tx_holding_empty & uart_control_bits[CTL_EMPTY_IRQ];
			tx_pin_o     <= tx_active ? tx_line : gpio_tx_out;
			tx_pin_oe    <= tx_active | tx_pin_dir_bit;
			rx_pin_o     <= gpio_rx_out;
			rx_pin_oe    <= ~rx_enable & rx_pin_dir_bit;
			rx_pullup_en <= rx_pin_pullup_bit;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_data_write_queues: assert property (data_wr |=> !tx_holding_empty && tx_hold == $past(w_byte))
		else $error("data write did not queue character");
	a_idle_load_frame: assert property (tx_load_idle && !data_wr |=> tx_holding_empty && tx_busy && !tx_shift[0]
		&& tx_shift[nine_bit_chars ? STOP_POS9 : STOP_POS8])
		else $error("idle load frame wrong");
	a_ninth_bit_load: assert property (tx_load_idle && nine_bit_chars |=> tx_shift[NINTH_POS] == $past(tx_ninth_bit))
		else $error("ninth bit not loaded");
	a_start_bit_out: assert property (tx_busy && tx_baud && tx_left == tx_len |=> !tx_line)
		else $error("start bit not driven");
	a_tx_done_set: assert property (tx_stop_end && tx_holding_empty |=> tx_done_flag && !tx_busy)
		else $error("transmit done not set");
	a_tx_done_clear: assert property (tx_done_flag && tx_done_vec_ack && !tx_stop_end |=> !tx_done_flag)
		else $error("transmit done not cleared");
	a_start_reject: assert property (rx_enable && rx_state == RX_START && rx_at10 && rx_maj |=> rx_state == RX_IDLE)
		else $error("noisy start accepted");
	a_rx_deliver: assert property (rx_deliver |=> rx_done_flag && rx_full && rx_data == $past(next_rx_data))
		else $error("character not delivered");
	a_rx_overrun: assert property (rx_lost |=> ovr_pend && $stable(rx_data) && rx_done_flag)
		else $error("overrun not tracked");
	a_overrun_visible: assert property (data_rd && ovr_pend |=> ovr_flag)
		else $error("buffered overrun not shown after read");
	a_read_clears: assert property (data_rd && !rx_deliver |=> !rx_done_flag)
		else $error("read did not clear receive done");
	a_tx_pin_drive: assert property (tx_enable |=> tx_pin_oe && tx_pin_o == $past(tx_line))
		else $error("transmit pin not driven");

endmodule

// ===== ast_remote.sv
// Remote serial device model on the far side of the transceiver
`timescale 1ns/1ps
module ast_remote (
	input  wire logic aclk,
	input  wire logic line_in,
	output logic      line_out
);
	parameter int BIT = 32;
	initial line_out = 1'b1;
	// ==========================================================
	// Frame sender, line idles high between frames
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		int i;
		line_out <= 1'b0;
		repeat (BIT) @(posedge aclk);
		for (i = 0; i < n; i++) begin
			line_out <= d[i];
			repeat (BIT) @(posedge aclk);
		end
		line_out <= stp;
		repeat (BIT) @(posedge aclk);
		line_out <= 1'b1;
		repeat (BIT) @(posedge aclk);
	endtask
	// Short low glitch, too brief to be a start bit
	task automatic spike(input int n);
		line_out <= 1'b0;
		repeat (n) @(posedge aclk);
		line_out <= 1'b1;
		repeat (BIT) @(posedge aclk);
	endtask
	// Frame capture at mid-bit, least significant bit first
	task automatic grab(input int n, output logic [8:0] d);
		int i;
		d = '0;
		@(negedge line_in);
		repeat (BIT / 2) @(posedge aclk);
		for (i = 0; i < n; i++) begin
			repeat (BIT) @(posedge aclk);
			d[i] = line_in;
		end
	endtask
endmodule

// ===== ast_transceiver_tb.sv
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
module ast_transceiver_tb;
	import ast_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, tx_done_vec_ack, irq_rx_done, irq_tx_done, irq_tx_empty;
	logic        rx_pin_i, rx_pin_dir_bit, rx_pin_o, rx_pin_oe, rx_pullup_en, rx_pin_pullup_bit;
	logic        tx_pin_dir_bit, tx_pin_o, tx_pin_oe;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_seen;
	logic [8:0]  g0, g1;
	int          mismatches, samples_checked, cyc;
	localparam logic [7:0] A_BD = {IDX_BAUD, 2'b00};
	localparam logic [7:0] A_CT = {IDX_CTRL, 2'b00};
	localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
	localparam logic [7:0] A_DT = {IDX_DATA, 2'b00};

	ast_transceiver uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .tx_done_vec_ack, .irq_rx_done, .irq_tx_done,
		.irq_tx_empty, .rx_pin_i, .gpio_rx_out(1'b0), .rx_pin_dir_bit,
		.rx_pin_pullup_bit, .rx_pin_o, .rx_pin_oe, .rx_pullup_en,
		.gpio_tx_out(1'b1), .tx_pin_dir_bit, .tx_pin_o, .tx_pin_oe
	);
	ast_remote #(.BIT(32)) rm (.aclk, .line_in(tx_pin_o), .line_out(rx_pin_i));

	// ==========================================================
	// Clock and hang guard
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end
	// ==========================================================
	// Checking and reporting
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checked=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// Register bus master
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		rresp_seen = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask
	task automatic wait_bit(input int b);
		int n;
		n = 0;
		do begin
			rd(A_ST, v);
			n++;
		end while (v[b] !== 1'b1 && n < 400);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{tx_done_vec_ack, tx_pin_dir_bit} = '0;
		rx_pin_dir_bit = 1'b1;
		rx_pin_pullup_bit = 1'b1;
		{mismatches, samples_checked, cyc} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk(A_ST, 32'h20);
		rchk(8'h00, 32'h0);
		chk(rresp_seen, RESP_SLVERR);
		chk({rx_pin_oe, tx_pin_oe, rx_pin_o}, 3'b100);
		wr(A_BD, 8'h01);
		wr(A_CT, 8'h38);
		chk({rx_pin_oe, tx_pin_oe, irq_tx_empty, rx_pullup_en}, 4'h7);
		fork
			begin
				rm.grab(8, g0);
				rm.grab(8, g1);
			end
			begin
				wr(A_DT, 8'hA5);
				wr(A_DT, 8'h5A);
				rchk(A_ST, 32'h00);
			end
		join
		chk(g0, 9'h0A5);
		chk(g1, 9'h05A);
		wait_bit(6);
		rchk(A_ST, 32'h60);
		chk({irq_tx_done, irq_tx_empty}, 2'b01);
		tx_done_vec_ack <= 1'b1;
		@(posedge aclk);
		tx_done_vec_ack <= 1'b0;
		@(posedge aclk);
		rchk(A_ST, 32'h20);
		rm.send(9'h03C, 8, 1'b1);
		wait_bit(7);
		rchk(A_DT, 32'h3C);
		rchk(A_ST, 32'h20);
		rm.spike(6);
		rm.send(9'h081, 8, 1'b0);
		wait_bit(7);
		rchk(A_ST, 32'hB0);
		rchk(A_DT, 32'h81);
		rm.send(9'h011, 8, 1'b1);
		rm.send(9'h022, 8, 1'b1);
		rchk(A_ST, 32'hA0);
		rchk(A_DT, 32'h11);
		rchk(A_ST, 32'h28);
		wr(A_CT, 8'hFD);
		fork
			rm.grab(9, g0);
			wr(A_DT, 8'h0F);
		join
		chk(g0, 9'h10F);
		rm.send(9'h1AA, 9, 1'b1);
		wait_bit(7);
		chk(irq_rx_done, 1'b1);
		rchk(A_CT, 32'hFE);
		rchk(A_DT, 32'hAA);
		chk(irq_rx_done, 1'b0);
		wait_bit(6);
		chk({irq_rx_done, irq_tx_done, irq_tx_empty}, 3'b011);
		wr(A_ST, 8'h40);
		rchk(A_ST, 32'h20);
		rx_pin_pullup_bit <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({irq_tx_done, rx_pullup_en}, 2'b00);
		final_report();
	end
endmodule
